/* hw/bud_branch_unit.sv */
// Branch processor with field decode, trap test, condition flags and an AXI4-Lite slave.
// What this block does
// - Bits 6-10 give source_gpr, the source register index.
// - Bits 6-10 give target_gpr, the result register index.
// - Bits 16-20 give rotate_count_field, the shift amount.
// - Bits 16-31 are a signed 16-bit immediate, sign-extended when widened.
// - Bits 11-20 give special_reg_number for special register moves.
// - Bits 11-15 select one of 16 segment registers; bit 11 ignored.
// - Bits 6-10 give trap_condition_mask, one bit per comparison outcome.
// - AND five comparison outcomes with mask bits 0-4; nonzero raises a trap.
// - Bits 16-19 give imm_nibble_field for the float status register.
// - Bits 16-31 are an unsigned 16-bit immediate, zero-extended when widened.
// - extended_opcode sits in 21-30, 22-30, 26-30 or bit 30 by form.
// - Branch targets ignore the two lowest bits, always word aligned.
// - Target is address plus offset, absolute, link register or count register.
// - A branch with link flag 1 writes the return address to link register.
// - Return address is the instruction directly after the branch.
// - Hold 32-bit condition_flags_reg, link register and count register.
// - Every branch runs unprivileged without a privilege exception.
// - A system call instruction raises an interrupt request.
// - Condition instructions copy a 4-bit field or combine single bits.
// - With record_flag 1 the result updates condition_flags_reg; else unchanged.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module bud_branch_unit #(
  parameter int ADDR_W = 8
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [ADDR_W-1:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic i_instr_valid,
  input wire logic [31:0] i_instr,
  input wire logic [31:0] i_instr_addr,
  input wire logic i_branch_cond_met,
  input wire logic [31:0] i_opa,
  input wire logic [31:0] i_opb,
  input wire logic i_rec_valid,
  input wire logic i_rec_flag,
  input wire logic [31:0] i_rec_value,
  input wire logic i_rec_overflow,
  output logic o_issue_done,
  output bud_pkg::bud_fields_t o_fields,
  output logic o_branch_taken,
  output logic [31:0] o_branch_target,
  output logic o_trap,
  output logic o_syscall_irq,
  output logic [31:0] o_spr_rdata
);
  initial begin
    if (ADDR_W < 5 || ADDR_W > 32) $error("ADDR_W must lie between 5 and 32.");
  end

  function automatic logic cr_bit_op(input logic [9:0] xo, input logic a, input logic b);
    case (xo)
      bud_pkg::XO_CR_AND: cr_bit_op = a & b;
      bud_pkg::XO_CR_OR: cr_bit_op = a | b;
      bud_pkg::XO_CR_XOR: cr_bit_op = a ^ b;
      bud_pkg::XO_CR_NAND: cr_bit_op = ~(a & b);
      bud_pkg::XO_CR_NOR: cr_bit_op = ~(a | b);
      bud_pkg::XO_CR_EQV: cr_bit_op = ~(a ^ b);
      bud_pkg::XO_CR_ANDC: cr_bit_op = a & ~b;
      default: cr_bit_op = a | ~b;
    endcase
  endfunction : cr_bit_op

  function automatic logic is_cr_logic(input logic [9:0] xo);
    is_cr_logic = xo == bud_pkg::XO_CR_AND || xo == bud_pkg::XO_CR_OR || xo == bud_pkg::XO_CR_XOR ||
                  xo == bud_pkg::XO_CR_NAND || xo == bud_pkg::XO_CR_NOR || xo == bud_pkg::XO_CR_EQV ||
                  xo == bud_pkg::XO_CR_ANDC || xo == bud_pkg::XO_CR_ORC;
  endfunction : is_cr_logic

  // Signed and unsigned comparison outcomes, ordered as mask bits 0 to 4.
  function automatic logic [4:0] compare_vec(input logic [31:0] a, input logic [31:0] b);
    compare_vec = {$signed(a) < $signed(b), $signed(a) > $signed(b), a == b, a < b, a > b};
  endfunction : compare_vec

  // Condition flags, link, count and control state.
  logic [31:0] condition_flags_reg;
  logic [31:0] link_reg;
  logic [31:0] count_reg;
  logic unit_enable;
  logic trap_seen;
  logic syscall_seen;
  logic [31:0] last_target;

  bud_pkg::bud_fields_t dec;
  bud_field_decode u_decode (
    .i_instr(i_instr),
    .o_fields(dec)
  );

  wire accept = i_instr_valid & unit_enable;
  wire [5:0] op = dec.primary_opcode;
  wire [9:0] xo = dec.extended_opcode;
  wire abs_flag = i_instr[1];
  wire link_flag = i_instr[0];
  wire is_b = op == bud_pkg::OP_BRANCH;
  wire is_bc = op == bud_pkg::OP_BRANCH_COND;
  wire is_blr = op == bud_pkg::OP_GROUP_XL && xo == bud_pkg::XO_BR_LINK;
  wire is_bctr = op == bud_pkg::OP_GROUP_XL && xo == bud_pkg::XO_BR_COUNT;
  wire is_branch = is_b | is_bc | is_blr | is_bctr;
  wire is_sc = op == bud_pkg::OP_SYSCALL;
  wire is_mcrf = op == bud_pkg::OP_GROUP_XL && xo == bud_pkg::XO_FIELD_COPY;
  wire is_crop = op == bud_pkg::OP_GROUP_XL && is_cr_logic(xo);
  wire is_tw = op == bud_pkg::OP_GROUP_X && xo == bud_pkg::XO_TRAP;
  wire is_twi = op == bud_pkg::OP_TRAP_IMM;
  wire is_mtspr = op == bud_pkg::OP_GROUP_X && xo == bud_pkg::XO_MOVE_TO_SPR;
  wire is_mfspr = op == bud_pkg::OP_GROUP_X && xo == bud_pkg::XO_MOVE_FROM_SPR;
  wire spr_lr = dec.special_reg_number == bud_pkg::SPR_NUM_LR;
  wire spr_ctr = dec.special_reg_number == bud_pkg::SPR_NUM_CTR;

  // Displacements are sign-extended to 32 bits before the add.
  wire [31:0] disp_long = {{6{i_instr[25]}}, i_instr[25:2], 2'b00};
  wire [31:0] disp_cond = {{16{i_instr[15]}}, i_instr[15:2], 2'b00};
  wire [31:0] disp = is_b ? disp_long : disp_cond;
  wire [31:0] rel_or_abs = abs_flag ? disp : i_instr_addr + disp;
  wire [31:0] raw_target = is_blr ? link_reg : (is_bctr ? count_reg : rel_or_abs);
  wire [31:0] target = {raw_target[31:2], 2'b00};
  // Branches carry no privilege check, so nothing here can fault on them.
  wire taken = accept & (is_b | (is_branch & ~is_b & i_branch_cond_met));
  wire do_link = accept & is_branch & link_flag;
  wire [31:0] return_addr = i_instr_addr + bud_pkg::INSTR_BYTES;

  // Trap operand b is the sign-extended immediate for the immediate form.
  wire [31:0] imm_sext = {{16{dec.twos_complement_imm16[15]}}, dec.twos_complement_imm16};
  wire [31:0] imm_zext = {16'h0000, dec.unsigned_imm16};
  wire [31:0] trap_b = is_twi ? imm_sext : i_opb;
  wire [4:0] trap_hits = compare_vec(i_opa, trap_b) & dec.trap_condition_mask;
  wire trap_now = accept & (is_tw | is_twi) & (|trap_hits);

  // Condition flag bit k lives at condition_flags_reg[31-k]; field n spans bits 4n..4n+3.
  wire [4:0] bt = i_instr[25:21];
  wire [4:0] ba = i_instr[20:16];
  wire [4:0] bb = i_instr[15:11];
  wire [2:0] dst_field = i_instr[25:23];
  wire [2:0] src_field = i_instr[20:18];
  wire [4:0] dst_lsb = 5'(5'd28 - {dst_field, 2'b00});
  wire [4:0] src_lsb = 5'(5'd28 - {src_field, 2'b00});
  wire crop_bit = cr_bit_op(xo, condition_flags_reg[5'(5'd31 - ba)], condition_flags_reg[5'(5'd31 - bb)]);
  wire [3:0] rec_field = {$signed(i_rec_value) < 0, $signed(i_rec_value) > 0, i_rec_value == 32'h0000_0000,
                          i_rec_overflow};

  // AXI4-Lite write: address and data are taken together once both are offered.
  wire wr_take = i_s_axi_awvalid & i_s_axi_wvalid & ~o_s_axi_bvalid;
  wire [7:0] wr_addr = 8'(i_s_axi_awaddr);
  wire wr_cr = wr_take && wr_addr == bud_pkg::REG_CR;
  wire wr_lr = wr_take && wr_addr == bud_pkg::REG_LR;
  wire wr_ctr = wr_take && wr_addr == bud_pkg::REG_CTR;
  wire wr_ctrl = wr_take && wr_addr == bud_pkg::REG_CTRL;
  wire wr_stat = wr_take && wr_addr == bud_pkg::REG_STATUS;
  wire wr_hit = wr_cr | wr_lr | wr_ctr | wr_ctrl | wr_stat | (wr_take && wr_addr == bud_pkg::REG_TARGET);
  wire [31:0] strb_mask = {{8{i_s_axi_wstrb[3]}}, {8{i_s_axi_wstrb[2]}}, {8{i_s_axi_wstrb[1]}},
                           {8{i_s_axi_wstrb[0]}}};
  assign o_s_axi_awready = wr_take;
  assign o_s_axi_wready = wr_take;

  wire rd_take = i_s_axi_arvalid & ~o_s_axi_rvalid;
  wire [7:0] rd_addr = 8'(i_s_axi_araddr);
  wire [31:0] status_word = {30'h0000_0000, syscall_seen, trap_seen};
  wire rd_hit = rd_addr == bud_pkg::REG_CR || rd_addr == bud_pkg::REG_LR || rd_addr == bud_pkg::REG_CTR ||
                rd_addr == bud_pkg::REG_CTRL || rd_addr == bud_pkg::REG_STATUS || rd_addr == bud_pkg::REG_TARGET;
  wire [31:0] rd_word = rd_addr == bud_pkg::REG_CR ? condition_flags_reg :
                        rd_addr == bud_pkg::REG_LR ? link_reg :
                        rd_addr == bud_pkg::REG_CTR ? count_reg :
                        rd_addr == bud_pkg::REG_CTRL ? {31'h0000_0000, unit_enable} :
                        rd_addr == bud_pkg::REG_STATUS ? status_word :
                        rd_addr == bud_pkg::REG_TARGET ? last_target : 32'h0000_0000;
  assign o_s_axi_arready = rd_take;

  // Next-state selection; the instruction stream wins over a bus write in the same cycle.
  logic [31:0] next_cr;
  logic [31:0] next_lr;
  logic [31:0] next_ctr;
  always_comb begin
    next_cr = condition_flags_reg;
    if (wr_cr) next_cr = (condition_flags_reg & ~strb_mask) | (i_s_axi_wdata & strb_mask);
    if (i_rec_valid && i_rec_flag) next_cr[31:28] = rec_field;
    if (accept && is_mcrf) next_cr[dst_lsb +: 4] = condition_flags_reg[src_lsb +: 4];
    if (accept && is_crop) next_cr[5'(5'd31 - bt)] = crop_bit;
    next_lr = link_reg;
    if (wr_lr) next_lr = (link_reg & ~strb_mask) | (i_s_axi_wdata & strb_mask);
    if (accept && is_mtspr && spr_lr) next_lr = i_opa;
    if (do_link) next_lr = return_addr;
    next_ctr = count_reg;
    if (wr_ctr) next_ctr = (count_reg & ~strb_mask) | (i_s_axi_wdata & strb_mask);
    if (accept && is_mtspr && spr_ctr) next_ctr = i_opa;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      condition_flags_reg <= bud_pkg::RST_CR;
      link_reg <= bud_pkg::RST_LR;
      count_reg <= bud_pkg::RST_CTR;
    end else begin
      condition_flags_reg <= next_cr;
      link_reg <= next_lr;
      count_reg <= next_ctr;
    end
  end

  // Sticky status: a new event in the clearing cycle keeps its bit set.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      unit_enable <= bud_pkg::RST_ENABLE;
      trap_seen <= 1'b0;
      syscall_seen <= 1'b0;
      last_target <= 32'h0000_0000;
    end else begin
      if (wr_ctrl && i_s_axi_wstrb[0]) unit_enable <= i_s_axi_wdata[bud_pkg::CTRL_ENABLE_BIT];
      trap_seen <= trap_now | (trap_seen & ~(wr_stat & i_s_axi_wstrb[0] & i_s_axi_wdata[bud_pkg::STAT_TRAP_BIT]));
      syscall_seen <= (accept & is_sc) |
                      (syscall_seen & ~(wr_stat & i_s_axi_wstrb[0] & i_s_axi_wdata[bud_pkg::STAT_SC_BIT]));
      if (taken) last_target <= target;
    end
  end

  // Issue results, one cycle after the instruction is taken.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_issue_done <= 1'b0;
      o_fields <= '0;
      o_branch_taken <= 1'b0;
      o_branch_target <= 32'h0000_0000;
      o_trap <= 1'b0;
      o_syscall_irq <= 1'b0;
      o_spr_rdata <= 32'h0000_0000;
    end else begin
      o_issue_done <= accept;
      if (accept) o_fields <= dec;
      o_branch_taken <= taken;
      if (taken) o_branch_target <= target;
      o_trap <= trap_now;
      o_syscall_irq <= accept & is_sc;
      if (accept && is_mfspr) o_spr_rdata <= spr_lr ? link_reg : (spr_ctr ? count_reg : imm_zext);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= bud_pkg::RESP_OKAY;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rresp <= bud_pkg::RESP_OKAY;
      o_s_axi_rdata <= 32'h0000_0000;
    end else begin
      if (wr_take) begin
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp <= wr_hit ? bud_pkg::RESP_OKAY : bud_pkg::RESP_SLVERR;
      end else if (i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
      if (rd_take) begin
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rdata <= rd_word;
        o_s_axi_rresp <= rd_hit ? bud_pkg::RESP_OKAY : bud_pkg::RESP_SLVERR;
      end else if (i_s_axi_rready) begin
        o_s_axi_rvalid <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_target_word_aligned: assert property (o_branch_taken |-> o_branch_target[1:0] == 2'b00)
    else $error("Branch target is not word aligned.");
  a_link_return_addr: assert property (do_link |=> link_reg == $past(i_instr_addr) + 32'h0000_0004)
    else $error("Link register does not hold the next instruction address.");
  a_rel_target_sext: assert property (accept && is_b && !abs_flag |=>
      o_branch_taken && o_branch_target == (($past(i_instr_addr) + {{6{$past(i_instr[25])}},
      $past(i_instr[25:2]), 2'b00}) & 32'hFFFF_FFFC))
    else $error("Relative branch target is wrong.");
  a_count_target: assert property (accept && is_bctr && i_branch_cond_met |=>
      o_branch_target == {$past(count_reg[31:2]), 2'b00})
    else $error("Count register branch target is wrong.");
  a_syscall_pulse: assert property (accept && is_sc |=> o_syscall_irq ##1 syscall_seen)
    else $error("System call did not raise its request.");
  a_trap_mask_hit: assert property (accept && is_tw && dec.trap_condition_mask[2] && i_opa == i_opb |=> o_trap)
    else $error("Equal trap condition did not trap.");
  a_trap_no_mask: assert property (accept && dec.trap_condition_mask == 5'h00 |=> !o_trap)
    else $error("Trap raised with an empty mask.");
  a_record_off_keeps: assert property (i_rec_valid && !i_rec_flag && !accept && !wr_cr |=>
      $stable(condition_flags_reg))
    else $error("Flags changed without the record flag.");
  a_record_field0: assert property (i_rec_valid && i_rec_flag && !accept && i_rec_value == 32'h0000_0000 |=>
      condition_flags_reg[31:28] == {3'b001, $past(i_rec_overflow)})
    else $error("Record of zero result did not set equal.");
  a_segment_select: assert property (o_issue_done |-> o_fields.segment_register_select ==
      $past(i_instr[19:16]))
    else $error("Segment selector decode is wrong.");
  a_branch_no_fault: assert property (o_branch_taken |-> !o_trap)
    else $error("Branch raised an exception.");

  c_rel_branch: cover property (accept && is_b && !abs_flag ##1 o_branch_taken);
  c_link_branch: cover property (accept && is_blr && link_flag && i_branch_cond_met);
  c_trap: cover property (o_trap);
  c_field_copy: cover property (accept && is_mcrf);
endmodule : bud_branch_unit

/* hw/bud_pkg.sv */
// Shared constants, opcodes and the decoded-field carrier for the branch unit.
package bud_pkg;
  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] REG_CR = 8'h00;
  localparam logic [7:0] REG_LR = 8'h04;
  localparam logic [7:0] REG_CTR = 8'h08;
  localparam logic [7:0] REG_CTRL = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_TARGET = 8'h14;
  // Reset values and field positions.
  localparam logic [31:0] RST_CR = 32'h0000_0000;
  localparam logic [31:0] RST_LR = 32'h0000_0000;
  localparam logic [31:0] RST_CTR = 32'h0000_0000;
  localparam logic RST_ENABLE = 1'b1;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int STAT_TRAP_BIT = 0;
  localparam int STAT_SC_BIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Distance from a branch to the instruction after it, in bytes.
  localparam logic [31:0] INSTR_BYTES = 32'h0000_0004;
  // Primary and extended opcodes.
  localparam logic [5:0] OP_TRAP_IMM = 6'h03;
  localparam logic [5:0] OP_BRANCH_COND = 6'h10;
  localparam logic [5:0] OP_SYSCALL = 6'h11;
  localparam logic [5:0] OP_BRANCH = 6'h12;
  localparam logic [5:0] OP_GROUP_XL = 6'h13;
  localparam logic [5:0] OP_GROUP_X = 6'h1F;
  localparam logic [9:0] XO_FIELD_COPY = 10'h000;
  localparam logic [9:0] XO_BR_LINK = 10'h010;
  localparam logic [9:0] XO_BR_COUNT = 10'h210;
  localparam logic [9:0] XO_CR_AND = 10'h101;
  localparam logic [9:0] XO_CR_OR = 10'h1C1;
  localparam logic [9:0] XO_CR_XOR = 10'h0C1;
  localparam logic [9:0] XO_CR_NAND = 10'h0E1;
  localparam logic [9:0] XO_CR_NOR = 10'h021;
  localparam logic [9:0] XO_CR_EQV = 10'h121;
  localparam logic [9:0] XO_CR_ANDC = 10'h081;
  localparam logic [9:0] XO_CR_ORC = 10'h1A1;
  localparam logic [9:0] XO_TRAP = 10'h004;
  localparam logic [9:0] XO_MOVE_TO_SPR = 10'h1D3;
  localparam logic [9:0] XO_MOVE_FROM_SPR = 10'h153;
  localparam logic [9:0] SPR_NUM_LR = 10'h100;
  localparam logic [9:0] SPR_NUM_CTR = 10'h120;

  typedef struct packed {
    logic [5:0] primary_opcode;
    logic [4:0] source_gpr;
    logic [4:0] target_gpr;
    logic [4:0] rotate_count_field;
    logic [15:0] twos_complement_imm16;
    logic [9:0] special_reg_number;
    logic [3:0] segment_register_select;
    logic [4:0] trap_condition_mask;
    logic [3:0] imm_nibble_field;
    logic [15:0] unsigned_imm16;
    logic [9:0] extended_opcode;
    logic [8:0] ext_opcode_arith;
    logic [4:0] ext_opcode_short;
    logic ext_opcode_bit;
    logic record_flag;
  } bud_fields_t;
endpackage : bud_pkg

/* hw/bud_field_decode.sv */
// Combinational split of one instruction word into its named fields.
`timescale 1ns/1ps
module bud_field_decode (
  input wire logic [31:0] i_instr,
  output bud_pkg::bud_fields_t o_fields
);
  // Instruction bit k counts from the most significant end, so it sits at i_instr[31-k].
  assign o_fields.primary_opcode = i_instr[31:26];
  assign o_fields.source_gpr = i_instr[25:21];
  assign o_fields.target_gpr = i_instr[25:21];
  assign o_fields.rotate_count_field = i_instr[15:11];
  assign o_fields.twos_complement_imm16 = i_instr[15:0];
  assign o_fields.special_reg_number = i_instr[20:11];
  // The first bit of the five-bit selector, i_instr[20], carries no meaning with 16 segment registers.
  assign o_fields.segment_register_select = i_instr[19:16];
  assign o_fields.trap_condition_mask = i_instr[25:21];
  assign o_fields.imm_nibble_field = i_instr[15:12];
  assign o_fields.unsigned_imm16 = i_instr[15:0];
  // All four placements are offered; the consumer picks the one its form uses.
  assign o_fields.extended_opcode = i_instr[10:1];
  assign o_fields.ext_opcode_arith = i_instr[9:1];
  assign o_fields.ext_opcode_short = i_instr[5:1];
  assign o_fields.ext_opcode_bit = i_instr[1];
  assign o_fields.record_flag = i_instr[0];
endmodule : bud_field_decode

/* tb/bud_seq_model.sv */
// Sequencer model that offers one instruction word at a time to the branch unit.
`timescale 1ns/1ps
module bud_seq_model (
  input wire logic i_core_clk,
  output logic o_valid,
  output logic [31:0] o_instr,
  output logic [31:0] o_addr,
  output logic o_cond,
  output logic [31:0] o_opa,
  output logic [31:0] o_opb
);
  initial begin
    {o_valid, o_instr, o_addr, o_cond, o_opa, o_opb} = '0;
  end

  task issue(input logic [31:0] w, input logic [31:0] a, input logic c, input logic [31:0] x);
    @(posedge i_core_clk);
    {o_valid, o_instr, o_addr, o_cond, o_opa, o_opb} <= {1'b1, w, a, c, x, x};
    @(posedge i_core_clk);
    // Released lines are scrambled so a stale word can never pass for a fresh one.
    {o_valid, o_instr, o_addr} <= {1'b0, ~w, ~a};
  endtask : issue
endmodule : bud_seq_model

/* tb/testbench.sv */
// Self-checking bench for the branch unit and field decoder.
`timescale 1ns/1ps
module testbench;
  logic core_clk, rst_n, awvalid, wvalid, bready, arvalid, rready, rec_valid, rec_flag, rec_ovf;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rec_value, rdat, rdata, target, spr_rdata, instr, iaddr, opa, opb;
  logic awready, wready, bvalid, arready, rvalid, issue_done, taken, trap, sc_irq, iv, cond;
  logic [1:0] bresp, rresp;
  bud_pkg::bud_fields_t fields;
  int failures = 0;
  int checks = 0;
  int cycles = 0;

  bud_seq_model bud_seq_model_i (.i_core_clk(core_clk), .o_valid(iv), .o_instr(instr), .o_addr(iaddr),
    .o_cond(cond), .o_opa(opa), .o_opb(opb));
  bud_branch_unit bud_branch_unit_i (.i_core_clk(core_clk), .i_rst_n(rst_n), .i_s_axi_awaddr(awaddr),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF),
    .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
    .i_instr_valid(iv), .i_instr(instr), .i_instr_addr(iaddr), .i_branch_cond_met(cond), .i_opa(opa),
    .i_opb(opb), .i_rec_valid(rec_valid), .i_rec_flag(rec_flag), .i_rec_value(rec_value),
    .i_rec_overflow(rec_ovf), .o_issue_done(issue_done), .o_fields(fields), .o_branch_taken(taken),
    .o_branch_target(target), .o_trap(trap), .o_syscall_irq(sc_irq), .o_spr_rdata(spr_rdata));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task complete_run();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end

  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Address and data are released separately, each on the rising edge after the falling edge where its own ready was seen.
  task axw(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw, ta, tw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge core_clk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    while (pa || pw) begin
      @(negedge core_clk);
      ta = pa && awready;
      tw = pw && wready;
      @(posedge core_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    do @(negedge core_clk); while (bvalid !== 1'b1);
    chk("bresp", bud_pkg::RESP_OKAY, bresp);
    @(posedge core_clk);
    bready <= 1'b0;
  endtask : axw

  task axr(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    @(posedge core_clk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do @(negedge core_clk); while (arready !== 1'b1);
    @(posedge core_clk);
    arvalid <= 1'b0;
    do @(negedge core_clk); while (rvalid !== 1'b1);
    d = rdata;
    chk("rresp", er, rresp);
    @(posedge core_clk);
    rready <= 1'b0;
  endtask : axr

  task rd(input logic [7:0] a, input logic [31:0] e, input string n);
    axr(a, bud_pkg::RESP_OKAY, rdat);
    chk(n, e, rdat);
  endtask : rd

  task go(input logic [31:0] w, input logic [31:0] a, input logic c, input logic [31:0] x, input logic d);
    bud_seq_model_i.issue(w, a, c, x);
    @(negedge core_clk);
    chk("issue_done", d, issue_done);
  endtask : go

  task rec(input logic f, input logic [31:0] v, input logic o, input logic [31:0] e);
    @(posedge core_clk);
    {rec_valid, rec_flag, rec_value, rec_ovf} <= {1'b1, f, v, o};
    @(posedge core_clk);
    rec_valid <= 1'b0;
    rd(bud_pkg::REG_CR, e, "cr record");
  endtask : rec

  task t_fields();
    logic [31:0] w;
    w = 32'hA5C3_7E59;
    go(w, 32'h0000_0100, 1'b0, 32'h0, 1'b1);
    chk("source_gpr", w[25:21], fields.source_gpr);
    chk("target_gpr", w[25:21], fields.target_gpr);
    chk("rotate_count", w[15:11], fields.rotate_count_field);
    chk("signed_imm", w[15:0], fields.twos_complement_imm16);
    chk("special_reg", w[20:11], fields.special_reg_number);
    chk("segment_select", w[19:16], fields.segment_register_select);
    chk("trap_mask", w[25:21], fields.trap_condition_mask);
    chk("imm_nibble", w[15:12], fields.imm_nibble_field);
    chk("unsigned_imm", w[15:0], fields.unsigned_imm16);
    chk("ext_opcode", w[10:1], fields.extended_opcode);
    chk("ext_opcode_arith", w[9:1], fields.ext_opcode_arith);
    chk("ext_opcode_short", w[5:1], fields.ext_opcode_short);
    chk("ext_opcode_bit", w[1], fields.ext_opcode_bit);
    chk("primary_opcode", w[31:26], fields.primary_opcode);
    chk("record_flag", w[0], fields.record_flag);
    $display("test fields ended");
  endtask : t_fields

  task t_branch();
    go({bud_pkg::OP_BRANCH, 24'hFFFFF0, 2'b01}, 32'h0000_1000, 1'b1, 32'h0, 1'b1);
    chk("taken", 1'b1, taken);
    chk("trap", 1'b0, trap);
    chk("target", 32'h0000_0FC0, target);
    rd(bud_pkg::REG_LR, 32'h0000_1004, "lr");
    go({bud_pkg::OP_BRANCH, 24'h000401, 2'b10}, 32'h0000_2000, 1'b1, 32'h0, 1'b1);
    chk("target", 32'h0000_1004, target);
    rd(bud_pkg::REG_LR, 32'h0000_1004, "lr");
    go({bud_pkg::OP_BRANCH_COND, 24'h000010, 2'b01}, 32'h0000_3000, 1'b0, 32'h0, 1'b1);
    chk("taken", 1'b0, taken);
    rd(bud_pkg::REG_LR, 32'h0000_3004, "lr");
    axw(bud_pkg::REG_LR, 32'h0000_2003);
    go({bud_pkg::OP_GROUP_XL, 15'h0, bud_pkg::XO_BR_LINK, 1'b0}, 32'h100, 1'b1, 32'h0, 1'b1);
    chk("target", 32'h0000_2000, target);
    axw(bud_pkg::REG_CTR, 32'h0000_3006);
    go({bud_pkg::OP_GROUP_XL, 15'h0, bud_pkg::XO_BR_COUNT, 1'b0}, 32'h100, 1'b1, 32'h0, 1'b1);
    chk("target", 32'h0000_3004, target);
    go({bud_pkg::OP_GROUP_X, 5'h3, bud_pkg::SPR_NUM_LR, bud_pkg::XO_MOVE_FROM_SPR, 1'b0}, 32'h0, 1'b0, 32'h0, 1'b1);
    chk("spr_rdata", 32'h0000_2003, spr_rdata);
    rd(bud_pkg::REG_TARGET, 32'h0000_3004, "last target");
    rd(bud_pkg::REG_CTR, 32'h0000_3006, "ctr");
    go({bud_pkg::OP_GROUP_X, 5'h3, bud_pkg::SPR_NUM_CTR, bud_pkg::XO_MOVE_TO_SPR, 1'b0}, 32'h0, 1'b0, 32'h5550, 1'b1);
    rd(bud_pkg::REG_CTR, 32'h0000_5550, "ctr move");
    $display("test branch ended");
  endtask : t_branch

  // Register minus one against immediate minus two only traps on greater and unsigned greater.
  task t_trap_sc();
    for (int k = 0; k < 5; k++) begin
      go({bud_pkg::OP_TRAP_IMM, 5'h10 >> k, 5'h0, 16'hFFFE}, 32'h400, 1'b0, 32'hFFFF_FFFF, 1'b1);
      chk("trap", (k == 1 || k == 4), trap);
    end
    // Register form: both operands are equal, so only the equal condition may trap.
    go({bud_pkg::OP_GROUP_X, 5'h04, 10'h000, bud_pkg::XO_TRAP, 1'b0}, 32'h600, 1'b0, 32'h1234_5678, 1'b1);
    chk("trap", 1'b1, trap);
    go({bud_pkg::OP_GROUP_X, 5'h1B, 10'h000, bud_pkg::XO_TRAP, 1'b0}, 32'h604, 1'b0, 32'h1234_5678, 1'b1);
    chk("trap", 1'b0, trap);
    go({bud_pkg::OP_SYSCALL, 24'h0, 2'b10}, 32'h500, 1'b0, 32'h0, 1'b1);
    chk("syscall", 1'b1, sc_irq);
    rd(bud_pkg::REG_STATUS, 32'h0000_0003, "status");
    axw(bud_pkg::REG_STATUS, 32'h0000_0003);
    rd(bud_pkg::REG_STATUS, 32'h0000_0000, "status");
    axr(8'h40, bud_pkg::RESP_SLVERR, rdat);
    chk("unmapped", 32'h0, rdat);
    $display("test trap and syscall ended");
  endtask : t_trap_sc

  task t_cond();
    logic [9:0] ops [8];
    logic [7:0] e;
    ops = '{bud_pkg::XO_CR_AND, bud_pkg::XO_CR_OR, bud_pkg::XO_CR_XOR, bud_pkg::XO_CR_NAND,
      bud_pkg::XO_CR_NOR, bud_pkg::XO_CR_EQV, bud_pkg::XO_CR_ANDC, bud_pkg::XO_CR_ORC};
    e = 8'hCE;
    axw(bud_pkg::REG_CR, 32'h0000_000A);
    go({bud_pkg::OP_GROUP_XL, 5'h0, 5'h1C, 5'h0, bud_pkg::XO_FIELD_COPY, 1'b0}, 32'h0, 1'b0, 32'h0, 1'b1);
    rd(bud_pkg::REG_CR, 32'hA000_000A, "cr copy");
    axw(bud_pkg::REG_CR, 32'h6000_0000);
    for (int i = 0; i < 8; i++) begin
      go({bud_pkg::OP_GROUP_XL, 5'h0, 5'h1, 5'h3, ops[i], 1'b0}, 32'h0, 1'b0, 32'h0, 1'b1);
      rd(bud_pkg::REG_CR, {e[i], 31'h6000_0000}, "cr op");
    end
    axw(bud_pkg::REG_CR, 32'h0000_00F0);
    rec(1'b1, 32'hFFFF_FFF0, 1'b1, 32'h9000_00F0);
    rec(1'b1, 32'h0, 1'b0, 32'h2000_00F0);
    rec(1'b0, 32'h0, 1'b0, 32'h2000_00F0);
    axw(bud_pkg::REG_CTRL, 32'h0);
    go({bud_pkg::OP_BRANCH, 24'h10, 2'b00}, 32'h0, 1'b1, 32'h0, 1'b0);
    chk("taken", 1'b0, taken);
    axw(bud_pkg::REG_CTRL, 32'h1);
    $display("test condition flags ended");
  endtask : t_cond

  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, rec_valid, rec_flag, rec_ovf} = '0;
    {awaddr, araddr, wdata, rec_value} = '0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(bud_pkg::REG_CTRL, 32'h0000_0001, "ctrl");
    rd(bud_pkg::REG_LR, bud_pkg::RST_LR, "lr");
    t_fields();
    t_branch();
    t_trap_sc();
    t_cond();
    complete_run();
  end
endmodule : testbench
